// [dv/pmm_data_mem_model.sv]
// far-side data memory that keeps the last forwarded write
`timescale 1ns/1ps
module pmm_data_mem_model
  import pmm_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  input  wire logic                       dataWe,
  input  wire logic [pmm_pkg::BYTE_W-1:0] dataWdata,
  output logic      [pmm_pkg::BYTE_W-1:0] lastWdata
);
  // own bus, so a write lands even while the fetch side is busy
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) lastWdata <= 8'h00;
    else if (dataWe) lastWdata <= dataWdata;
  end
endmodule

// [dv/pmm_program_memory_asserts.sv]
// concurrent port checks for the program memory unit
`timescale 1ns/1ps
module pmm_program_memory_asserts
  import pmm_pkg::*;
(
  input wire logic                       sys_clk,
  input wire logic                       nrst,
  input wire logic                       pcStep,
  input wire logic                       pcJump,
  input wire logic                       irqEnter,
  input wire logic [pmm_pkg::PC_W-1:0]   pc,
  input wire logic                       indRead,
  input wire logic                       indWrite,
  input wire logic [pmm_pkg::PTR_W-1:0]  indPtr,
  input wire logic                       indDone,
  input wire logic                       indBusy,
  input wire logic                       indWriteIgnored,
  input wire logic                       dataRe,
  input wire logic                       dataWe,
  input wire logic [pmm_pkg::PTR_W-1:0]  dataAddr,
  input wire logic [pmm_pkg::RADR_W-1:0] regAddr,
  input wire logic                       regRd,
  input wire logic [pmm_pkg::REG_W-1:0]  regRdata
);
  // one clock domain; everything is quiet while reset is held
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // a program read that the idle unit accepts
  wire pmReq = indRead && indPtr[PTR_PM_BIT] && !indBusy;
  // the extra cycle: done lands two cycles after the request, never sooner
  property p_done; pmReq |-> ##2 indDone; endproperty
  a_done: assert property (p_done) else $error("program read late");
  property p_busy; pmReq |=> indBusy [*2] ##1 !indBusy; endproperty
  a_busy: assert property (p_busy) else $error("busy span wrong");
  property p_pmwr;
    indWrite && indPtr[PTR_PM_BIT] && !indBusy |=> indWriteIgnored && !dataWe;
  endproperty
  a_pmwr: assert property (p_pmwr) else $error("write leaked");
  property p_fwd;
    indRead && !indPtr[PTR_PM_BIT] && !indBusy |=>
      dataRe && dataAddr == $past(indPtr);
  endproperty
  a_fwd: assert property (p_fwd) else $error("data read lost");
  property p_rst; $rose(nrst) |-> pc == RESET_VEC; endproperty
  a_rst: assert property (p_rst) else $error("reset vector wrong");
  property p_irq; irqEnter |=> pc == IRQ_VEC; endproperty
  a_irq: assert property (p_irq) else $error("irq vector wrong");
  property p_step;
    pcStep && !pcJump && !irqEnter |=> pc == $past(pc) + PC_ONE;
  endproperty
  a_step: assert property (p_step) else $error("counter step wrong");
  property p_id;
    regRd && regAddr == ID_OFS |=> regRdata[15:12] == {HI_ZERO, ID_TOP};
  endproperty
  a_id: assert property (p_id) else $error("id top bits wrong");
endmodule
bind pmm_program_memory pmm_program_memory_asserts u_chk (.*);

// [dv/pmm_program_memory_tb_top.sv]
// self-checking bench for the program memory unit
`timescale 1ns/1ps
module pmm_program_memory_tb_top;
  import pmm_pkg::*;
  localparam logic [11:0] PID = 12'h3C7; // arbitrary value
  localparam logic [5:0]  MJ  = 6'h05;   // arbitrary value
  localparam logic [5:0]  MN  = 6'h2A;   // arbitrary value
  logic              sys_clk, nrst, pcStep, pcJump, irqEnter, indRead;
  logic              indWrite, regWr, regRd, loadWe, execBlocked, indDone;
  logic              indBusy, indWriteIgnored, dataRe, dataWe;
  logic [PC_W-1:0]   pcTarget, pc, a, p;
  logic [PTR_W-1:0]  indPtr, dataAddr, regAddr, regWdata, regRdata;
  logic [BYTE_W-1:0] indWdata, indData, dataWdata, lastWdata, d;
  logic [IMPL_W-1:0] loadAddr;
  logic [WORD_W-1:0] loadData, instr;
  logic [WORD_W-1:0] mem [16384];
  logic [IMPL_W-1:0] pts [12];
  pmm_region_t       fetchRegion, indRegion;
  logic [4:0]        c;
  int                mismatches = 0, comparisons = 0;
  pmm_program_memory #(.PART_ID(PID), .MAJOR_REV(MJ), .MINOR_REV(MN))
    uut (.*);
  pmm_data_mem_model model (.*);
  // 8 ns clock
  always #4 sys_clk = ~sys_clk;
  // one counted comparison, reported at once on a difference
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one register cycle; a read compares the word of the next cycle
  task automatic acc(input logic w, logic [15:0] x, logic [15:0] v);
    @(posedge sys_clk);
    regWr <= w;
    regRd <= !w;
    regAddr <= x;
    regWdata <= v;
    @(posedge sys_clk);
    {regWr, regRd} <= 2'b00;
    #1 if (!w) chk(regRdata, v);
  endtask
  // jump, then let the fetched word land
  task automatic go(input logic [PC_W-1:0] t);
    @(posedge sys_clk);
    pcJump <= 1'b1;
    pcTarget <= t;
    @(posedge sys_clk);
    pcJump <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // region of a word under a config value; sizes under 011 give half
  function automatic pmm_region_t region(logic [13:0] x, logic [4:0] f);
    logic [2:0] s;
    s = f[2:0] < 3'h3 ? 3'h3 : f[2:0];
    if (!f[4] && x >= 14'h3F80) return REGION_STOR;
    if (!f[3] && x < (14'h0200 << (3'h7 - s))) return REGION_BOOT;
    return REGION_APP;
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    {sys_clk, nrst, pcStep, pcJump, irqEnter, indRead, indWrite} = '0;
    {regWr, regRd, loadWe, pcTarget, indPtr, indWdata} = '0;
    {regAddr, regWdata, loadAddr, loadData} = '0;
    pts = '{14'h01FF, 14'h0200, 14'h03FF, 14'h0400, 14'h07FF, 14'h0800,
            14'h0FFF, 14'h1000, 14'h1FFF, 14'h2000, 14'h3F7F, 14'h3F80};
    void'($urandom(26480));
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    #1 chk(pc, RESET_VEC);
    // fill every word, so any fetch or program read has a known answer
    for (int i = 0; i < 16384; i++) begin
      @(posedge sys_clk);
      loadWe <= 1'b1;
      loadAddr <= 14'(i);
      mem[i] = 14'($urandom);
      loadData <= mem[i];
    end
    @(posedge sys_clk);
    loadWe <= 1'b0;
    acc(1'b0, ID_OFS, {4'h3, PID});
    acc(1'b1, ID_OFS, 16'h0000);
    acc(1'b0, ID_OFS, {4'h3, PID});
    acc(1'b0, REV_OFS, {4'h2, MJ, MN});
    acc(1'b0, 16'h8007, 16'h0000);
    acc(1'b0, CFG_OFS, 16'h001F);
    $display("id words done");
    // every size, storage on and off; the last pass is the default
    for (int s = 0; s < 9; s++) begin
      c = s == 8 ? 5'h1F : {s[0], 1'b0, s[2:0]};
      acc(1'b1, CFG_OFS, {11'h000, 2'h3, c[2:0]});
      acc(1'b1, CFG_OFS, {11'h000, c});
      acc(1'b1, CFG_OFS, {11'h000, c[4:3], ~c[2:0]});
      acc(1'b0, CFG_OFS, {11'h000, c[4:3], c[3] ? ~c[2:0] : c[2:0]});
      for (int j = 0; j < 12; j++) begin
        a = {j[0], pts[j]};
        go(a);
        chk(pc, a);
        chk(instr, mem[pts[j]]);
        chk(fetchRegion, region(pts[j], c));
        chk(execBlocked, region(pts[j], c) == REGION_STOR);
      end
    end
    $display("partition done");
    // interrupt entry beats a jump in the same cycle
    @(posedge sys_clk);
    {irqEnter, pcJump} <= 2'b11;
    @(posedge sys_clk);
    {irqEnter, pcJump} <= 2'b00;
    #1 chk(pc, IRQ_VEC);
    // boot 512 and storage on, so program reads land in all regions
    c = 5'h07;
    acc(1'b1, CFG_OFS, {11'h000, c});
    go(15'h7FFF);
    acc(1'b0, STAT_OFS, 16'h7FFF);
    // program reads with a second read dropped while busy, dropped writes, forwarded traffic
    for (int k = 0; k < 8; k++) begin
      // the first two land in storage, aliased, and in boot
      a = k == 0 ? 15'h7F90 : k == 1 ? 15'h0010 : 15'($urandom);
      d = 8'($urandom);
      p = pc;
      @(posedge sys_clk);
      {indRead, pcStep} <= 2'b11;
      indPtr <= {1'b1, a};
      @(posedge sys_clk);
      indPtr <= {1'b1, ~a};
      pcStep <= 1'b0;
      #1 chk(pc, 15'(p + 15'h0001));
      chk(indDone, 1'b0);
      @(posedge sys_clk);
      indRead <= 1'b0;
      #1 chk(indDone, 1'b1);
      chk(indData, 8'(mem[a[13:0]]));
      chk(indRegion, region(a[13:0], c));
      @(posedge sys_clk);
      #1 chk(indBusy, 1'b0);
      chk(indDone, 1'b0);
      @(posedge sys_clk);
      indWrite <= 1'b1;
      indWdata <= d;
      @(posedge sys_clk);
      indPtr <= {1'b0, a};
      indRead <= 1'b1;
      #1 chk(indWriteIgnored, 1'b1);
      chk(dataWe, 1'b0);
      @(posedge sys_clk);
      {indWrite, indRead} <= 2'b00;
      #1 chk(dataAddr, {1'b0, a});
      chk(dataRe, 1'b1);
      @(posedge sys_clk);
      #1 chk(lastWdata, d);
    end
    $display("indirect done");
    end_of_test();
  end
endmodule

// [hdl/pmm_flash_array.sv]
// two read port program word array with a loading port
`timescale 1ns/1ps
module pmm_flash_array #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 14
) (
  input  wire logic              sys_clk,
  input  wire logic [ADDR_W-1:0] fetchAddr,
  output logic      [DATA_W-1:0] fetchData,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData,
  input  wire logic              loadWe,
  input  wire logic [ADDR_W-1:0] loadAddr,
  input  wire logic [DATA_W-1:0] loadData
);

  // ********************************
  // storage
  // ********************************
  logic [DATA_W-1:0] words [2**ADDR_W];

  // separate fetch and data ports so both proceed in the same cycle
  always_ff @(posedge sys_clk) begin
    fetchData <= words[fetchAddr];
    rdData    <= words[rdAddr];
  end

  // loading only; the core's indirect port has no path to this write
  always_ff @(posedge sys_clk) begin
    if (loadWe) begin
      words[loadAddr] <= loadData;
    end
  end

endmodule

// [hdl/pmm_pkg.sv]
// constants, types and the memory map shared by the program memory unit
package pmm_pkg;

  // ********************************
  // widths
  // ********************************
  localparam int PC_W   = 15;  // program counter width
  localparam int WORD_W = 14;  // instruction word width
  localparam int IMPL_W = 14;  // implemented address bits, 16384 words
  localparam int PTR_W  = 16;  // indirect pointer, high and low byte
  localparam int BYTE_W = 8;
  localparam int REG_W  = 16;
  localparam int RADR_W = 16;

  // ********************************
  // vectors and pointer layout
  // ********************************
  localparam logic [PC_W-1:0] RESET_VEC = 15'h0000;
  localparam logic [PC_W-1:0] IRQ_VEC   = 15'h0004;
  localparam logic [PC_W-1:0] PC_ONE    = 15'h0001;
  localparam int PTR_PM_BIT = 15;  // bit 7 of the pointer high byte

  // ********************************
  // register offsets
  // ********************************
  localparam logic [RADR_W-1:0] REV_OFS  = 16'h8005;
  localparam logic [RADR_W-1:0] ID_OFS   = 16'h8006;
  localparam logic [RADR_W-1:0] CFG_OFS  = 16'h800A;
  localparam logic [RADR_W-1:0] STAT_OFS = 16'h8010;

  // ********************************
  // field layouts and fixed bits
  // ********************************
  localparam logic [1:0] ID_TOP  = 2'h3;  // bits 13:12 of the part word
  localparam logic [1:0] REV_TOP = 2'h2;  // bits 13:12 of the revision word
  localparam logic [1:0] HI_ZERO = 2'h0;  // bits 15:14 of both words
  localparam int CFG_STOR_BIT = 4;
  localparam int CFG_BOOT_BIT = 3;
  localparam int CFG_SIZE_LSB = 0;
  localparam int CFG_SIZE_W   = 3;
  localparam logic [CFG_SIZE_W-1:0] SIZE_RST = 3'h7;

  // ********************************
  // partition map
  // ********************************
  localparam logic [IMPL_W-1:0] END_512  = 14'h01FF;
  localparam logic [IMPL_W-1:0] END_1K   = 14'h03FF;
  localparam logic [IMPL_W-1:0] END_2K   = 14'h07FF;
  localparam logic [IMPL_W-1:0] END_4K   = 14'h0FFF;
  localparam logic [IMPL_W-1:0] END_HALF = 14'h1FFF;  // 8192 words
  localparam logic [IMPL_W-1:0] STOR_BASE = 14'h3F80; // last 128 words

  typedef enum logic [1:0] {
    REGION_APP  = 2'h0,
    REGION_BOOT = 2'h1,
    REGION_STOR = 2'h2
  } pmm_region_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_HOLD = 3'b100
  } pmm_state_t;

  typedef struct packed {
    pmm_state_t            st;
    logic [PC_W-1:0]       pc;
    logic [BYTE_W-1:0]     indData;
    logic                  indDone;
    logic                  indBusy;
    logic                  indWriteIgnored;
    logic                  dataRe;
    logic                  dataWe;
    logic [PTR_W-1:0]      dataAddr;
    logic [BYTE_W-1:0]     dataWdata;
    logic [REG_W-1:0]      regRdata;
    logic                  bootEnN;
    logic [CFG_SIZE_W-1:0] bootSize;
    logic                  storEnN;
    pmm_region_t           fetchRegion;
    logic                  execBlocked;
    pmm_region_t           indRegion;
  } pmm_state_s_t;

endpackage

// [hdl/pmm_program_memory.sv]
// program counter, program memory map, indirect read path and id words
//
// Function
// - the part word is read-only, bits 11:0 the part id, 13:12 read one.
// - the revision word is read-only, bit 13 reads one and bit 12 zero.
// - revision bits 11:6 hold the six-bit major revision.
// - revision bits 5:0 hold the six-bit minor revision.
// - the program counter is 15 bits over a 32K by 14-bit space.
// - only 16384 words exist and higher addresses wrap into them.
// - reset starts at 0000h and interrupt entry goes to 0004h.
// - pointer high bit 7 set sends indirect reads to program memory.
// - an indirect program read returns the low eight bits of the word.
// - indirect writes to program addresses leave program memory alone.
// - an indirect program read takes one extra cycle.
// - flash splits into application, boot and storage by three fields.
// - with both enables at one all flash is application.
// - fetch and data accesses use separate buses in the same cycle.
// - an enabled storage region is the last 128 words, not executable.
// - boot size 111 is 512 words doubling to 011 at 8192, larger is half.
`timescale 1ns/1ps
module pmm_program_memory
  import pmm_pkg::*;
#(
  parameter logic [11:0] PART_ID   = 12'hA5C, // arbitrary value
  parameter logic [5:0]  MAJOR_REV = 6'h01,   // arbitrary value
  parameter logic [5:0]  MINOR_REV = 6'h02    // arbitrary value
) (
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  // core program counter control
  input  wire logic                       pcStep,
  input  wire logic                       pcJump,
  input  wire logic [pmm_pkg::PC_W-1:0]   pcTarget,
  input  wire logic                       irqEnter,
  output logic      [pmm_pkg::PC_W-1:0]   pc,
  output logic      [pmm_pkg::WORD_W-1:0] instr,
  output pmm_pkg::pmm_region_t            fetchRegion,
  output logic                            execBlocked,
  // indirect access from the core
  input  wire logic                       indRead,
  input  wire logic                       indWrite,
  input  wire logic [pmm_pkg::PTR_W-1:0]  indPtr,
  input  wire logic [pmm_pkg::BYTE_W-1:0] indWdata,
  output logic      [pmm_pkg::BYTE_W-1:0] indData,
  output logic                            indDone,
  output logic                            indBusy,
  output logic                            indWriteIgnored,
  output pmm_pkg::pmm_region_t            indRegion,
  // forwarded data memory access
  output logic                            dataRe,
  output logic                            dataWe,
  output logic      [pmm_pkg::PTR_W-1:0]  dataAddr,
  output logic      [pmm_pkg::BYTE_W-1:0] dataWdata,
  // register port
  input  wire logic [pmm_pkg::RADR_W-1:0] regAddr,
  input  wire logic [pmm_pkg::REG_W-1:0]  regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [pmm_pkg::REG_W-1:0]  regRdata,
  // array loading
  input  wire logic                       loadWe,
  input  wire logic [pmm_pkg::IMPL_W-1:0] loadAddr,
  input  wire logic [pmm_pkg::WORD_W-1:0] loadData
);
  import pmm_pkg::*;

  // ********************************
  // functions
  // ********************************

  // last boot address; sizes past half the array clamp to half
  function automatic logic [IMPL_W-1:0] bootEnd(
    input logic [CFG_SIZE_W-1:0] size
  );
    logic [IMPL_W-1:0] e;
    e = END_HALF;
    unique case (size)
      3'h7:    e = END_512;
      3'h6:    e = END_1K;
      3'h5:    e = END_2K;
      3'h4:    e = END_4K;
      default: e = END_HALF;
    endcase
    return e;
  endfunction

  // partition of one word address under the current settings
  function automatic pmm_region_t regionOf(
    input logic [IMPL_W-1:0]     a,
    input logic                  bootN,
    input logic [CFG_SIZE_W-1:0] size,
    input logic                  storN
  );
    pmm_region_t r;
    r = REGION_APP;
    if (!storN && a >= STOR_BASE) begin
      r = REGION_STOR;
    end else if (!bootN && a <= bootEnd(size)) begin
      r = REGION_BOOT;
    end
    return r;
  endfunction

  // ********************************
  // state
  // ********************************
  pmm_state_s_t      cur;
  pmm_state_s_t      next_cur;
  logic [WORD_W-1:0] pmWord;
  logic [IMPL_W-1:0] fetchAddr;
  logic [IMPL_W-1:0] rdAddr;
  logic              ptrIsPm;

  // upper pc bit is dropped so high addresses alias the array
  assign fetchAddr = cur.pc[IMPL_W-1:0];
  assign rdAddr    = indPtr[IMPL_W-1:0];
  assign ptrIsPm   = indPtr[PTR_PM_BIT];

  pmm_flash_array #(
    .ADDR_W (IMPL_W),
    .DATA_W (WORD_W)
  ) u_array (
    .sys_clk   (sys_clk),
    .fetchAddr (fetchAddr),
    .fetchData (instr),
    .rdAddr    (rdAddr),
    .rdData    (pmWord),
    .loadWe    (loadWe),
    .loadAddr  (loadAddr),
    .loadData  (loadData)
  );

  // ********************************
  // next state
  // ********************************
  always_comb begin
    next_cur = cur;
    next_cur.indDone         = 1'b0;
    next_cur.indWriteIgnored = 1'b0;
    next_cur.dataRe          = 1'b0;
    next_cur.dataWe          = 1'b0;

    // interrupt entry beats a jump, a jump beats a step
    if (irqEnter) begin
      next_cur.pc = IRQ_VEC;
    end else if (pcJump) begin
      next_cur.pc = pcTarget;
    end else if (pcStep) begin
      next_cur.pc = cur.pc + PC_ONE;
    end

    // classification lines up with the word that appears on instr
    next_cur.fetchRegion = regionOf(fetchAddr, cur.bootEnN, cur.bootSize,
                                    cur.storEnN);
    next_cur.execBlocked = (next_cur.fetchRegion == REGION_STOR);

    // indirect path; requests while a program read runs are not taken
    unique case (cur.st)
      ST_IDLE: begin
        if (indRead && ptrIsPm) begin
          next_cur.st        = ST_READ;
          next_cur.indBusy   = 1'b1;
          next_cur.indRegion = regionOf(rdAddr, cur.bootEnN, cur.bootSize,
                                        cur.storEnN);
        end else if (indWrite && ptrIsPm) begin
          next_cur.indWriteIgnored = 1'b1;
        end else if (indRead || indWrite) begin
          next_cur.dataRe    = indRead;
          next_cur.dataWe    = indWrite;
          next_cur.dataAddr  = indPtr;
          next_cur.dataWdata = indWdata;
        end
      end
      ST_READ: begin
        next_cur.indData = pmWord[BYTE_W-1:0];
        next_cur.indDone = 1'b1;
        next_cur.st      = ST_HOLD;
      end
      // the extra cycle: busy still stands, so a request here is dropped
      ST_HOLD: begin
        next_cur.indBusy = 1'b0;
        next_cur.st      = ST_IDLE;
      end
      default: begin
        next_cur.st      = ST_IDLE;
        next_cur.indBusy = 1'b0;
      end
    endcase

    // register writes; the id words ignore writes
    if (regWr && regAddr == CFG_OFS) begin
      next_cur.storEnN = regWdata[CFG_STOR_BIT];
      next_cur.bootEnN = regWdata[CFG_BOOT_BIT];
      // size is frozen once the boot region is enabled
      if (cur.bootEnN) begin
        next_cur.bootSize = regWdata[CFG_SIZE_LSB +: CFG_SIZE_W];
      end
    end

    // register reads answer in the following cycle, unmapped reads zero
    next_cur.regRdata = '0;
    if (regRd) begin
      unique case (regAddr)
        ID_OFS:
          next_cur.regRdata = {HI_ZERO, ID_TOP, PART_ID};
        REV_OFS:
          next_cur.regRdata = {HI_ZERO, REV_TOP,
                               MAJOR_REV,
                               MINOR_REV};
        CFG_OFS: begin
          next_cur.regRdata[CFG_STOR_BIT] = cur.storEnN;
          next_cur.regRdata[CFG_BOOT_BIT] = cur.bootEnN;
          next_cur.regRdata[CFG_SIZE_LSB +: CFG_SIZE_W] = cur.bootSize;
        end
        STAT_OFS:
          next_cur.regRdata = {1'b0, cur.pc};
        default:
          next_cur.regRdata = '0;
      endcase
    end
  end

  // ********************************
  // registers
  // ********************************

  // enables reset to one so the whole flash starts as application
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur                 <= '0;
      cur.st              <= ST_IDLE;
      cur.pc              <= RESET_VEC;
      cur.bootEnN         <= 1'b1;
      cur.storEnN         <= 1'b1;
      cur.bootSize        <= SIZE_RST;
      cur.fetchRegion     <= REGION_APP;
      cur.indRegion       <= REGION_APP;
    end else begin
      cur <= next_cur;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign pc              = cur.pc;
  assign fetchRegion     = cur.fetchRegion;
  assign execBlocked     = cur.execBlocked;
  assign indData         = cur.indData;
  assign indDone         = cur.indDone;
  assign indBusy         = cur.indBusy;
  assign indWriteIgnored = cur.indWriteIgnored;
  assign indRegion       = cur.indRegion;
  assign dataRe          = cur.dataRe;
  assign dataWe          = cur.dataWe;
  assign dataAddr        = cur.dataAddr;
  assign dataWdata       = cur.dataWdata;
  assign regRdata        = cur.regRdata;

endmodule
